// >>> dv/fifo_link_props.sv
// Concurrent checks on the link between the FIFO device end and host end.
// Assumes one clock, ref_clk, and the bench's active-high reset.
`timescale 1ns/10ps
module fifo_link_props (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic reset_n,
   input wire logic port_a_select_n,
   input wire logic port_a_write_not_read,
   input wire logic port_a_xfer_gate,
   input wire logic port_a_mailbox_sel,
   input wire logic port_b_select_n,
   input wire logic port_b_write_not_read,
   input wire logic port_a_bus_dev_oe,
   input wire logic port_b_bus_dev_oe,
   input wire logic full_flag_n,
   input wire logic empty_flag_n,
   input wire logic almost_empty_flag_n,
   input wire logic almost_full_flag_n,
   input wire logic a_to_b_mail_flag_n,
   input wire logic b_to_a_mail_flag_n
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset || !reset_n);
   wire selA  = !port_a_select_n && port_a_write_not_read && port_a_xfer_gate;
   wire wrA   = selA && !port_a_mailbox_sel && full_flag_n;
   wire mailA = selA && port_a_mailbox_sel && a_to_b_mail_flag_n;
   // Two idle edges first, so no earlier word is still crossing
   sequence quiet_write;
      !wrA [*2] ##1 (wrA && !empty_flag_n);
   endsequence
   sequence empty_sync;
      !empty_flag_n [*2] ##1 empty_flag_n;
   endsequence
   bus_a_drive_a: assert property (
      port_a_bus_dev_oe == (!port_a_select_n && !port_a_write_not_read))
      else $error("port A bus drive wrong");
   bus_b_drive_a: assert property (
      port_b_bus_dev_oe == (!port_b_select_n && !port_b_write_not_read))
      else $error("port B bus drive wrong");
   reset_flags_a: assert property (disable iff (1'b0) !reset_n |-> !full_flag_n &&
      !empty_flag_n && !almost_empty_flag_n && almost_full_flag_n &&
      a_to_b_mail_flag_n && b_to_a_mail_flag_n) else $error("reset flag levels wrong");
   full_release_a: assert property ($rose(reset_n) |-> !full_flag_n [*2] ##1 full_flag_n)
      else $error("full flag release timing wrong");
   empty_rise_a: assert property (quiet_write |=> empty_sync)
      else $error("empty flag rise timing wrong");
   mail_store_a: assert property (mailA |=> !a_to_b_mail_flag_n)
      else $error("mail write did not lower flag");
   mail_cause_a: assert property ($fell(a_to_b_mail_flag_n) |-> $past(mailA))
      else $error("mail flag fell without a write");
   gate_idle_a: assert property (!port_a_xfer_gate |=> $stable(a_to_b_mail_flag_n))
      else $error("mail flag moved with gate low");
   reverse_mail_a: assert property (b_to_a_mail_flag_n)
      else $error("reverse mail flag low without a write");
   // Full is held low for two edges after release while almost-full is still high
   full_almost_a: assert property ($past(reset_n, 2) && !full_flag_n |->
      !almost_full_flag_n) else $error("almost full high while full");
endmodule : fifo_link_props

// >>> dv/tb_dual_clock_fifo_mailbox_ports.sv
// Bench: host end drives device end; a queue model predicts every popped word.
// Assumes a 100 MHz ref_clk and that the design files are compiled first.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin num_errors++; \
   $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module tb_dual_clock_fifo_mailbox_ports;
   logic                            ref_clk, reset, linkUp, pushValid, pushReady;
   logic                            mailValid, mailReady, popValid, popReady, tk;
   logic [1:0]                      offsetSel;
   logic [fifo_pkg::WORD_WIDTH-1:0] pushData, mailData, popData, exp;
   logic [fifo_pkg::WORD_WIDTH-1:0] model[$];
   int                              num_errors, n_checks, s, i, x, idle, fill;
   fifo_link_if link ();
   fifo_device_end i_fifo_device_end (.ref_clk(ref_clk), .reset(reset), .link(link));
   fifo_host_end i_fifo_host_end (.ref_clk(ref_clk), .reset(reset), .link(link),
      .offsetSel(offsetSel), .linkUp(linkUp), .pushValid(pushValid), .pushData(pushData),
      .pushReady(pushReady), .mailValid(mailValid), .mailData(mailData),
      .mailReady(mailReady), .popValid(popValid), .popData(popData), .popReady(popReady));
   fifo_link_props i_props (.ref_clk(ref_clk), .reset(reset), .reset_n(link.reset_n),
      .port_a_select_n(link.port_a_select_n), .port_a_write_not_read(link.port_a_write_not_read),
      .port_a_xfer_gate(link.port_a_xfer_gate), .port_a_mailbox_sel(link.port_a_mailbox_sel),
      .port_b_select_n(link.port_b_select_n), .port_b_write_not_read(link.port_b_write_not_read),
      .port_a_bus_dev_oe(link.port_a_bus_dev_oe), .port_b_bus_dev_oe(link.port_b_bus_dev_oe),
      .full_flag_n(link.full_flag_n), .empty_flag_n(link.empty_flag_n),
      .almost_empty_flag_n(link.almost_empty_flag_n),
      .almost_full_flag_n(link.almost_full_flag_n),
      .a_to_b_mail_flag_n(link.a_to_b_mail_flag_n),
      .b_to_a_mail_flag_n(link.b_to_a_mail_flag_n));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // Inputs move only at the falling edge, so sampling here sees settled handshakes
   always @(posedge ref_clk) begin
      if (pushValid && pushReady) model.push_back(pushData);
      if (popValid && popReady) begin
         exp = model.size() > 0 ? model.pop_front() : 'x;
         `CHK("popData", exp, popData)
      end
   end
   task automatic report_and_stop;
      $display("Checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop
   task automatic stop_on_hang(input string nm);
      num_errors++;
      $display("ERROR %s expected 1 seen 0", nm);
      report_and_stop();
   endtask : stop_on_hang
   task automatic do_reset(input logic [1:0] sel);
      int k;
      reset = 1'b1;
      offsetSel = sel;
      model.delete();
      repeat (10) @(negedge ref_clk);
      reset = 1'b0;
      for (k = 0; k < 40 && !linkUp; k++) @(negedge ref_clk);
      if (!linkUp) stop_on_hang("linkUp");
      repeat (4) @(negedge ref_clk);
   endtask : do_reset
   initial begin
      reset = 1'b1;
      offsetSel = 2'h0;
      {pushValid, mailValid, popReady} = 3'h0;
      pushData = '0;
      mailData = '0;
      void'($urandom(32'h22ae4681));
      for (s = 3; s >= 0; s--) begin
         do_reset(s[1:0]);
         x = s == 3 ? 16 : s == 2 ? 12 : s == 1 ? 8 : 4;
         mailData = 36'({$urandom(), $urandom()});
         mailValid = 1'b1;
         for (i = 0; i < 20 && !mailReady; i++) @(negedge ref_clk);
         if (!mailReady) stop_on_hang("mailReady");
         @(negedge ref_clk);
         mailValid = 1'b0;
         repeat (4) @(negedge ref_clk);
         `CHK("a_to_b_mail_flag_n", 1'b0, link.a_to_b_mail_flag_n)
         `CHK("a_to_b_mail_reg", mailData, i_fifo_device_end.aToBMail)
         pushValid = 1'b1;
         idle = 0;
         for (i = 0; i < 300 && idle < 20; i++) begin
            @(posedge ref_clk);
            tk = pushReady;
            @(negedge ref_clk);
            if (tk) pushData = 36'({$urandom(), $urandom()});
            idle = tk ? 0 : idle + 1;
         end
         pushValid = 1'b0;
         `CHK("stored words", 67, model.size())
         `CHK("full_flag_n", 1'b0, link.full_flag_n)
         for (i = 0; i < 100 && model.size() > 0; i++) begin
            popReady = 1'b1;
            repeat ($urandom_range(8, 1)) @(negedge ref_clk);
            popReady = 1'b0;
            repeat (8) @(negedge ref_clk);
            fill = model.size() > 2 ? model.size() - 2 : 0;
            `CHK("almost_empty_flag_n", 1'(fill > x), link.almost_empty_flag_n)
            `CHK("almost_full_flag_n", 1'(fill < 64 - x), link.almost_full_flag_n)
            `CHK("empty_flag_n", 1'(fill > 0), link.empty_flag_n)
         end
         if (model.size() > 0) stop_on_hang("drain");
         $display("Test with offset %0d done", x);
      end
      report_and_stop();
   end
endmodule : tb_dual_clock_fifo_mailbox_ports

// >>> hw/fifo_device_end.sv
// Device end: 64 x 36 FIFO from port A to port B, two mailbox registers, flags.
// Assumes both ports are clocked by ref_clk (coincident port clocks) and that
// the host keeps link reset_n low for the hold time before using the FIFO.
`timescale 1ns/10ps
// Behaviour
// - Host holds reset_n low four edges.
// - Reset input may change at any time.
// - Reset clears pointers, sets fixed flag levels.
// - Full flag rises second edge after release.
// - Host resets device before first FIFO write.
// - Reset release loads offset from select pins.
// - Port A drives B-to-A mail when reading.
// - FIFO write needs select, write, gate, full.
// - FIFO read needs select, read, gate, empty.
// - Port B drives output register or mail.
// - Port A mail read frees B-to-A mailbox.
// - Port B mail read frees A-to-B mailbox.
// - Gate low means no port operation.
// - Status flags pass two flip-flop stages.
// - Empty flag low ignores FIFO reads.
// - Read pointer advances per output register load.
// - Empty flag rises second edge after write.
// - Edges inside skew window do not count.
// - Mailbox writes store the port bus.
// - Mail write lowers flag; blocked while flag low.
// - Full flag low ignores FIFO writes.
// - Almost flags compare fill against offset.
module fifo_device_end (
   input  wire logic   ref_clk,
   input  wire logic   reset,
   fifo_link_if.device link
);
   localparam int W = fifo_pkg::WORD_WIDTH;

   logic [W-1:0]                        mem [fifo_pkg::FIFO_DEPTH];
   logic                                devReset;
   logic                                releaseMeta;
   logic                                releaseSync;
   logic [fifo_pkg::OFFSET_WIDTH-1:0]   almostOffset;
   logic [fifo_pkg::PTR_WIDTH-1:0]      wrPtr;
   logic [fifo_pkg::PTR_WIDTH-1:0]      rdPtr;
   logic [fifo_pkg::PTR_WIDTH-1:0]      next_wrPtr;
   logic [fifo_pkg::PTR_WIDTH-1:0]      next_rdPtr;
   logic [fifo_pkg::PTR_WIDTH-1:0]      rdPtrStage;
   logic [fifo_pkg::PTR_WIDTH-1:0]      wrPtrStage;
   logic [fifo_pkg::PTR_WIDTH-1:0]      fillSeenByA;
   logic [fifo_pkg::PTR_WIDTH-1:0]      fillSeenByB;
   logic [fifo_pkg::PTR_WIDTH-1:0]      offsetWide;
   logic                                fullReady;
   logic                                fullN;
   logic                                emptyN;
   logic                                almostEmptyN;
   logic                                almostFullN;
   logic [W-1:0]                        outReg;
   logic [W-1:0]                        aToBMail;
   logic [W-1:0]                        bToAMail;
   logic                                aToBFlagN;
   logic                                bToAFlagN;
   logic                                aAccess;
   logic                                bAccess;
   logic                                aWriteFifo;
   logic                                aWriteMail;
   logic                                aReadMail;
   logic                                bReadFifo;
   logic                                bReadMail;
   logic                                bWriteMail;

   function automatic logic [fifo_pkg::OFFSET_WIDTH-1:0] offsetDecode(
      input logic sel1,
      input logic sel0
   );
      case ({sel1, sel0})
         2'b11:   offsetDecode = fifo_pkg::OFFSET_SEL_11;
         2'b10:   offsetDecode = fifo_pkg::OFFSET_SEL_10;
         2'b01:   offsetDecode = fifo_pkg::OFFSET_SEL_01;
         default: offsetDecode = fifo_pkg::OFFSET_SEL_00;
      endcase
   endfunction : offsetDecode

   // Either the system reset or the link pin resets the FIFO state at once
   assign devReset = reset || !link.reset_n;

   // Release seen through two flops so the offset capture is glitch free
   always_ff @(posedge ref_clk or posedge devReset) begin
      if (devReset) begin
         releaseMeta <= 1'b0;
         releaseSync <= 1'b0;
      end else begin
         releaseMeta <= 1'b1;
         releaseSync <= releaseMeta;
      end
   end

   // Offset follows the select pins until the release settles, then freezes
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         almostOffset <= fifo_pkg::OFFSET_RESET;
      end else if (!releaseSync) begin
         almostOffset <= offsetDecode(link.offset_select_1, link.offset_select_0);
      end
   end

   // Port decoding; nothing happens while a gate is low
   assign aAccess    = !link.port_a_select_n && link.port_a_xfer_gate;
   assign bAccess    = !link.port_b_select_n && link.port_b_xfer_gate;
   assign aWriteFifo = aAccess && link.port_a_write_not_read && !link.port_a_mailbox_sel
                       && fullN;
   assign aWriteMail = aAccess && link.port_a_write_not_read && link.port_a_mailbox_sel
                       && aToBFlagN;
   assign aReadMail  = aAccess && !link.port_a_write_not_read && link.port_a_mailbox_sel;
   assign bReadFifo  = bAccess && !link.port_b_write_not_read && !link.port_b_mailbox_sel
                       && emptyN;
   assign bReadMail  = bAccess && !link.port_b_write_not_read && link.port_b_mailbox_sel;
   assign bWriteMail = bAccess && link.port_b_write_not_read && link.port_b_mailbox_sel
                       && bToAFlagN;
   // A port A FIFO read and a port B FIFO write decode to nothing

   assign next_wrPtr = wrPtr + {6'h00, aWriteFifo};
   assign next_rdPtr = rdPtr + {6'h00, bReadFifo};

   always_ff @(posedge ref_clk) begin
      if (aWriteFifo) begin
         mem[wrPtr[fifo_pkg::ADDR_WIDTH-1:0]] <= link.port_a_bus;
      end
   end

   always_ff @(posedge ref_clk or posedge devReset) begin
      if (devReset) begin
         wrPtr  <= '0;
         rdPtr  <= '0;
         outReg <= '0;
      end else begin
         wrPtr <= next_wrPtr;
         if (bReadFifo) begin
            outReg <= mem[rdPtr[fifo_pkg::ADDR_WIDTH-1:0]];
            rdPtr  <= next_rdPtr;
         end
      end
   end

   // First stage: each side sees the other pointer one edge late. The flag
   // register is the second stage, so a pointer move reaches the far flag on
   // the second edge; with coincident clocks the skew window is always met.
   always_ff @(posedge ref_clk or posedge devReset) begin
      if (devReset) begin
         rdPtrStage <= '0;
         wrPtrStage <= '0;
      end else begin
         rdPtrStage <= rdPtr;
         wrPtrStage <= wrPtr;
      end
   end

   // Own-side moves count at once so the FIFO never over- or under-runs
   assign offsetWide  = {2'b00, almostOffset};
   assign fillSeenByA = next_wrPtr - rdPtrStage;
   assign fillSeenByB = wrPtrStage - next_rdPtr;

   // Holds the full flag low one extra edge so it rises on the second edge
   always_ff @(posedge ref_clk or posedge devReset) begin
      if (devReset) begin
         fullReady <= 1'b0;
      end else begin
         fullReady <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge devReset) begin
      if (devReset) begin
         fullN       <= 1'b0;
         almostFullN <= 1'b1;
      end else begin
         fullN       <= fullReady && (fillSeenByA != fifo_pkg::FULL_COUNT);
         almostFullN <= (fillSeenByA + offsetWide) < fifo_pkg::FULL_COUNT;
      end
   end

   always_ff @(posedge ref_clk or posedge devReset) begin
      if (devReset) begin
         emptyN       <= 1'b0;
         almostEmptyN <= 1'b0;
      end else begin
         emptyN       <= fillSeenByB != fifo_pkg::EMPTY_COUNT;
         almostEmptyN <= fillSeenByB > offsetWide;
      end
   end

   // Mailboxes: a new write wins over a same-edge read of the old mail
   always_ff @(posedge ref_clk or posedge devReset) begin
      if (devReset) begin
         aToBMail  <= '0;
         aToBFlagN <= 1'b1;
      end else begin
         if (bReadMail) begin
            aToBFlagN <= 1'b1;
         end
         if (aWriteMail) begin
            aToBMail  <= link.port_a_bus;
            aToBFlagN <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge devReset) begin
      if (devReset) begin
         bToAMail  <= '0;
         bToAFlagN <= 1'b1;
      end else begin
         if (aReadMail) begin
            bToAFlagN <= 1'b1;
         end
         if (bWriteMail) begin
            bToAMail  <= link.port_b_bus;
            bToAFlagN <= 1'b0;
         end
      end
   end

   // Output enables follow select and direction alone, not the gate or clock
   assign link.port_a_bus_dev_oe  = !link.port_a_select_n && !link.port_a_write_not_read;
   assign link.port_a_bus_dev_out = bToAMail;
   assign link.port_b_bus_dev_oe  = !link.port_b_select_n && !link.port_b_write_not_read;
   assign link.port_b_bus_dev_out = link.port_b_mailbox_sel ? aToBMail : outReg;

   assign link.full_flag_n         = fullN;
   assign link.empty_flag_n        = emptyN;
   assign link.almost_empty_flag_n = almostEmptyN;
   assign link.almost_full_flag_n  = almostFullN;
   assign link.a_to_b_mail_flag_n  = aToBFlagN;
   assign link.b_to_a_mail_flag_n  = bToAFlagN;
endmodule : fifo_device_end

// >>> hw/fifo_host_end.sv
// Host end: resets the device, writes words and mail on port A,
// reads FIFO words on port B into a two-entry buffer.
// Assumes the device runs on the same ref_clk.
`timescale 1ns/10ps
module fifo_host_end (
   input  wire logic                            ref_clk,
   input  wire logic                            reset,
   fifo_link_if.host                            link,
   input  wire logic [1:0]                      offsetSel,
   output logic                                 linkUp,
   input  wire logic                            pushValid,
   input  wire logic [fifo_pkg::WORD_WIDTH-1:0] pushData,
   output logic                                 pushReady,
   input  wire logic                            mailValid,
   input  wire logic [fifo_pkg::WORD_WIDTH-1:0] mailData,
   output logic                                 mailReady,
   output logic                                 popValid,
   output logic [fifo_pkg::WORD_WIDTH-1:0]      popData,
   input  wire logic                            popReady
);
   logic [2:0]                          holdCount;
   logic                                resetN;
   logic [1:0]                          offsetPins;
   logic                                aValid;
   logic                                aIsMail;
   logic [fifo_pkg::WORD_WIDTH-1:0]     aData;
   logic                                aAccepted;
   logic                                aLoad;
   logic                                readPending;
   logic                                readIssue;
   logic                                bufInReady;

   // Link reset is held low for the required edges after system reset
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         holdCount  <= 3'h0;
         resetN     <= 1'b0;
         offsetPins <= 2'b00;
      end else begin
         offsetPins <= offsetSel;
         if (holdCount != fifo_pkg::RESET_HOLD_EDGES) begin
            holdCount <= holdCount + 3'h1;
         end
         resetN <= (holdCount == fifo_pkg::RESET_HOLD_EDGES);
      end
   end

   assign linkUp               = resetN;
   assign link.reset_n         = resetN;
   assign link.offset_select_0 = offsetPins[0];
   assign link.offset_select_1 = offsetPins[1];

   // Port A request stage: held until the device would accept it
   assign aAccepted = aValid && (aIsMail ? link.a_to_b_mail_flag_n : link.full_flag_n);
   assign aLoad     = linkUp && (!aValid || aAccepted);
   assign pushReady = aLoad;
   assign mailReady = aLoad && !pushValid;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         aValid  <= 1'b0;
         aIsMail <= 1'b0;
         aData   <= '0;
      end else if (aLoad) begin
         aValid  <= pushValid || mailValid;
         aIsMail <= !pushValid;
         aData   <= pushValid ? pushData : mailData;
      end
   end

   assign link.port_a_select_n       = !linkUp;
   assign link.port_a_write_not_read = 1'b1;
   assign link.port_a_xfer_gate      = aValid;
   assign link.port_a_mailbox_sel    = aIsMail;
   assign link.port_a_bus_host_out   = aData;
   assign link.port_a_bus_host_oe    = linkUp;

   // One read in flight at a time, so buffer room seen at issue is still there
   assign readIssue = linkUp && link.empty_flag_n && !readPending && bufInReady;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         readPending <= 1'b0;
      end else begin
         readPending <= readIssue;
      end
   end

   assign link.port_b_select_n       = !linkUp;
   assign link.port_b_write_not_read = 1'b0;
   assign link.port_b_xfer_gate      = readIssue;
   assign link.port_b_mailbox_sel    = 1'b0;
   assign link.port_b_bus_host_out   = '0;
   assign link.port_b_bus_host_oe    = 1'b0;

   two_entry_buffer #(
      .WIDTH(fifo_pkg::WORD_WIDTH)
   ) readBuffer (
      .ref_clk  (ref_clk),
      .reset    (reset),
      .inValid  (readPending),
      .inData   (link.port_b_bus),
      .inReady  (bufInReady),
      .outValid (popValid),
      .outReady (popReady),
      .outData  (popData)
   );
endmodule : fifo_host_end

// >>> hw/fifo_link_if.sv
// Pin-level link between the FIFO device end and the host end.
// Assumes both ends run on the same ref_clk; data buses are resolved here.
`timescale 1ns/10ps
interface fifo_link_if;
   logic                                reset_n;
   logic                                offset_select_0;
   logic                                offset_select_1;
   logic                                port_a_select_n;
   logic                                port_a_write_not_read;
   logic                                port_a_xfer_gate;
   logic                                port_a_mailbox_sel;
   logic                                port_b_select_n;
   logic                                port_b_write_not_read;
   logic                                port_b_xfer_gate;
   logic                                port_b_mailbox_sel;
   logic [fifo_pkg::WORD_WIDTH-1:0]     port_a_bus_host_out;
   logic                                port_a_bus_host_oe;
   logic [fifo_pkg::WORD_WIDTH-1:0]     port_a_bus_dev_out;
   logic                                port_a_bus_dev_oe;
   logic [fifo_pkg::WORD_WIDTH-1:0]     port_b_bus_host_out;
   logic                                port_b_bus_host_oe;
   logic [fifo_pkg::WORD_WIDTH-1:0]     port_b_bus_dev_out;
   logic                                port_b_bus_dev_oe;
   logic [fifo_pkg::WORD_WIDTH-1:0]     port_a_bus;
   logic [fifo_pkg::WORD_WIDTH-1:0]     port_b_bus;
   logic                                full_flag_n;
   logic                                empty_flag_n;
   logic                                almost_empty_flag_n;
   logic                                almost_full_flag_n;
   logic                                a_to_b_mail_flag_n;
   logic                                b_to_a_mail_flag_n;

   // Wire level: the device wins a fight; an undriven bus reads as zero
   assign port_a_bus = port_a_bus_dev_oe ? port_a_bus_dev_out :
                       (port_a_bus_host_oe ? port_a_bus_host_out : '0);
   assign port_b_bus = port_b_bus_dev_oe ? port_b_bus_dev_out :
                       (port_b_bus_host_oe ? port_b_bus_host_out : '0);

   modport device (
      input  reset_n, offset_select_0, offset_select_1,
      input  port_a_select_n, port_a_write_not_read, port_a_xfer_gate, port_a_mailbox_sel,
      input  port_b_select_n, port_b_write_not_read, port_b_xfer_gate, port_b_mailbox_sel,
      input  port_a_bus, port_b_bus,
      output port_a_bus_dev_out, port_a_bus_dev_oe, port_b_bus_dev_out, port_b_bus_dev_oe,
      output full_flag_n, empty_flag_n, almost_empty_flag_n, almost_full_flag_n,
      output a_to_b_mail_flag_n, b_to_a_mail_flag_n
   );

   modport host (
      output reset_n, offset_select_0, offset_select_1,
      output port_a_select_n, port_a_write_not_read, port_a_xfer_gate, port_a_mailbox_sel,
      output port_b_select_n, port_b_write_not_read, port_b_xfer_gate, port_b_mailbox_sel,
      output port_a_bus_host_out, port_a_bus_host_oe, port_b_bus_host_out, port_b_bus_host_oe,
      input  port_a_bus, port_b_bus,
      input  full_flag_n, empty_flag_n, almost_empty_flag_n, almost_full_flag_n,
      input  a_to_b_mail_flag_n, b_to_a_mail_flag_n
   );
endinterface : fifo_link_if

// >>> hw/fifo_pkg.sv
// Shared constants for the port-A-to-port-B FIFO with mailbox bypass registers.
// Assumes both ends and the link run on one clock, ref_clk, at 100 MHz.
package fifo_pkg;
   localparam int          WORD_WIDTH       = 36;
   localparam int          FIFO_DEPTH       = 64;
   localparam int          ADDR_WIDTH       = 6;
   localparam int          PTR_WIDTH        = 7;
   localparam int          OFFSET_WIDTH     = 5;
   localparam int          BUFFER_WIDTH     = 36;

   // Almost-full / almost-empty offset selected by the two select pins
   localparam logic [4:0]  OFFSET_SEL_11    = 5'h10;
   localparam logic [4:0]  OFFSET_SEL_10    = 5'h0c;
   localparam logic [4:0]  OFFSET_SEL_01    = 5'h08;
   localparam logic [4:0]  OFFSET_SEL_00    = 5'h04;
   localparam logic [4:0]  OFFSET_RESET     = 5'h04;

   // Words held when the FIFO is full or empty, at pointer width
   localparam logic [6:0]  FULL_COUNT       = 7'h40;
   localparam logic [6:0]  EMPTY_COUNT      = 7'h00;

   // Rising edges for which the host holds the link reset low
   localparam logic [2:0]  RESET_HOLD_EDGES = 3'h4;

   // Skew after a write before a read-side edge counts as a sync cycle
   localparam int          CLOCK_PERIOD_NS  = 10;
   localparam int          FLAG_SKEW_WINDOW_NS = 8;
   localparam int          FLAG_SKEW_CYCLES =
      (FLAG_SKEW_WINDOW_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
endpackage : fifo_pkg

// >>> hw/two_entry_buffer.sv
// Two-entry valid/ready buffer for words read out of port B.
// Assumes one clock; the drain side may stall freely.
`timescale 1ns/10ps
module two_entry_buffer #(
   parameter int WIDTH = fifo_pkg::BUFFER_WIDTH
) (
   input  wire logic             ref_clk,
   input  wire logic             reset,
   input  wire logic             inValid,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  inReady,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   logic [WIDTH-1:0] slot [2];
   logic             wrIdx;
   logic             rdIdx;
   logic [1:0]       count;
   logic             doPush;
   logic             doPop;

   assign inReady  = (count != 2'h2);
   assign outValid = (count != 2'h0);
   assign doPush   = inValid && inReady;
   assign doPop    = outValid && outReady;
   assign outData  = slot[rdIdx];

   always_ff @(posedge ref_clk) begin
      if (doPush) begin
         slot[wrIdx] <= inData;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         wrIdx <= 1'b0;
         rdIdx <= 1'b0;
         count <= 2'h0;
      end else begin
         if (doPush) begin
            wrIdx <= ~wrIdx;
         end
         if (doPop) begin
            rdIdx <= ~rdIdx;
         end
         count <= count + {1'b0, doPush} - {1'b0, doPop};
      end
   end
endmodule : two_entry_buffer
